// ---- hw/hs_i2c_pkg.sv ----
// shared constants, state types and byte helpers for the high-speed
// two-wire write link; imported by both ends of the link
`default_nettype none
package hs_i2c_pkg;
  // byte patterns on the wire
  localparam logic [4:0] MCODE_PREFIX = 5'h01;
  localparam logic [2:0] MCODE_ID = 3'h1; // free bits, value arbitrary
  localparam logic [4:0] DEV_ADDR_PREFIX = 5'h13;
  localparam logic WRITE_BIT = 1'b0;
  // bit slots within one byte frame
  localparam logic [3:0] LAST_DATA_SLOT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] SLOT_DONE = 4'h9;
  // control byte field positions
  localparam int CTRL_PD = 0;
  localparam int CTRL_SEL = 1;
  localparam int CTRL_LOAD = 4;
  localparam int CTRL_EXT = 6;
  // word field positions
  localparam int HI_LSB = 2;
  localparam int LO_MSB_FIELD = 6;
  // bus timing: one bit is four quarters of the link clock
  localparam int CORE_PERIOD_PS = 4000;
  localparam int QUARTER_NS = 80;
  localparam int QUARTER_CYCLES = (QUARTER_NS * 1000) / CORE_PERIOD_PS;
  localparam logic [4:0] QUARTER_LAST = 5'(QUARTER_CYCLES - 1);

  typedef enum logic [2:0]
  {
    PH_IDLE = 3'b000,
    PH_FIRST = 3'b001,
    PH_CTRL = 3'b010,
    PH_DATA = 3'b011,
    PH_DONE = 3'b100
  } rx_phase_t;

  typedef enum logic [3:0]
  {
    M_IDLE = 4'b0000,
    M_START = 4'b0001,
    M_MCODE = 4'b0010,
    M_RSTART = 4'b0011,
    M_ADDR = 4'b0100,
    M_CTRL = 4'b0101,
    M_HI = 4'b0110,
    M_LO = 4'b0111,
    M_STOP = 4'b1000
  } tx_state_t;

  function automatic logic is_mcode(input logic [7:0] b);
    return b[7:3] == MCODE_PREFIX;
  endfunction

  function automatic logic [7:0] addr_byte(input logic [1:0] pins);
    return {DEV_ADDR_PREFIX, pins, WRITE_BIT};
  endfunction
endpackage
`default_nettype wire

// ---- hw/i2c_link_if.sv ----
// two-wire link between the bus master and the converter slave
// clock is push-pull from the master; data is open drain with pull-up
`timescale 1ns/10ps
`default_nettype none
interface i2c_link_if;
  logic scl;
  logic sda_m_out;
  logic sda_m_oe;
  logic sda_s_out;
  logic sda_s_oe;
  wire logic sda;

  // wired-and with pull-up: any enabled low driver wins
  assign sda = ~((sda_m_oe & ~sda_m_out) | (sda_s_oe & ~sda_s_out));

  modport master(output scl, output sda_m_out, output sda_m_oe, input sda);
  modport slave(input scl, output sda_s_out, output sda_s_oe, input sda);
endinterface
`default_nettype wire

// ---- hw/sample_sync.sv ----
// two-flop synchroniser for levels entering a clock domain
// assumes the consumer reads only q, never the first stage
`timescale 1ns/10ps
`default_nettype none
module sample_sync
#(
  parameter int WIDTH = 1
)
(
  input wire logic clk,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  // no reset: pure data path, settles within two edges
  always_ff @(posedge clk)
  begin
    meta <= d;
    q <= meta;
  end
endmodule
`default_nettype wire

// ---- hw/hs_mode_i2c_write_slave.sv ----
// converter-side receiver for high-speed write transactions
// assumes link_clk oversamples the bus at least twice per quarter bit
//
// Notes on behaviour
// - master sends master code first, upper bits fixed
// - master code always left unacknowledged
// - repeated start then address with write bit
// - acknowledge address, control and data bytes
// - control byte follows the acknowledged address
// - control LSB selects powerdown or conversion data
// - flag low: repeating high/low byte word pairs
// - flag high: exactly two powerdown bytes accepted
// - first byte carries data bits nine to two
// - second byte top bits carry bits one, zero
// - powerdown mode bits on top, rest zero
// - second powerdown byte top bits zero, acknowledged
// - repeated start returns to write addressing
// - control byte selects mode and channel
`timescale 1ns/10ps
`default_nettype none
module hs_mode_i2c_write_slave
(
  i2c_link_if.slave link,
  input wire logic link_clk,
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic addr_pin_hi,
  input wire logic addr_pin_lo,
  output logic word_valid,
  output logic [1:0] word_channel,
  output logic [1:0] word_load_mode,
  output logic [1:0] word_ext_addr,
  output logic [9:0] word_data,
  output logic powerdown_valid,
  output logic powerdown_mode_hi,
  output logic powerdown_mode_lo
);
  import hs_i2c_pkg::*;

  logic [0:0] link_rst_q;
  logic [3:0] line_q;
  logic scl_p;
  logic sda_p;
  rx_phase_t phase;
  rx_phase_t next_phase;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic hs_active;
  logic ack_pend;
  logic sda_drive;
  logic [7:0] ctrl;
  logic [7:0] hi_byte;
  logic second;
  logic [9:0] out_data;
  logic [1:0] out_chan;
  logic [1:0] out_load;
  logic [1:0] out_ext;
  logic out_is_pd;
  logic xfer_tgl;
  logic [0:0] xfer_s;
  logic xfer_p;

  // reset enters the link domain through its own synchroniser
  sample_sync #(.WIDTH(1)) u_rst_sync
  (
    .clk(link_clk),
    .d(rst_n),
    .q(link_rst_q)
  );

  // bus lines and strap pins are all asynchronous to link_clk
  sample_sync #(.WIDTH(4)) u_line_sync
  (
    .clk(link_clk),
    .d({link.scl, link.sda, addr_pin_hi, addr_pin_lo}),
    .q(line_q)
  );

  // bus event decode on the synchronised lines
  wire link_rst_n = link_rst_q[0];
  wire scl_s = line_q[3];
  wire sda_s = line_q[2];
  wire [1:0] pins_s = line_q[1:0];
  wire start_ev = scl_s & scl_p & sda_p & ~sda_s;
  wire stop_ev = scl_s & scl_p & ~sda_p & sda_s;
  wire scl_rise = scl_s & ~scl_p;
  wire scl_fall = ~scl_s & scl_p;

  // byte completion and its decode
  wire [7:0] full = {shreg[6:0], sda_s};
  wire in_frame = phase != PH_IDLE;
  wire byte_done = in_frame & scl_rise & (bitcnt == LAST_DATA_SLOT);
  wire first_mc = (phase == PH_FIRST) & is_mcode(full);
  wire first_hit = (phase == PH_FIRST) & hs_active &
    (full == addr_byte(pins_s));
  wire ctrl_pd = ctrl[CTRL_PD];
  wire pair_end = (phase == PH_DATA) & second;
  // master code never matches the address, so it is never acked
  wire want_ack = first_hit | (phase == PH_CTRL) |
    (phase == PH_DATA);

  // open drain: only ever pull low
  assign link.sda_s_out = 1'b0;
  assign link.sda_s_oe = sda_drive;

  // transaction phase after each received byte
  always_comb
  begin
    next_phase = phase;
    unique case (phase)
      PH_FIRST: next_phase = first_hit ? PH_CTRL : PH_DONE;
      PH_CTRL: next_phase = PH_DATA;
      // powerdown takes one pair only, further bytes go unacked
      PH_DATA: next_phase = (second & ctrl_pd) ? PH_DONE : PH_DATA;
      default: next_phase = phase;
    endcase
  end

  // previous line levels for edge detection
  always_ff @(posedge link_clk)
  begin
    if (!link_rst_n)
    begin
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end
    else
    begin
      scl_p <= scl_s;
      sda_p <= sda_s;
    end
  end

  // phase and high-speed state; a stop ends high-speed mode
  always_ff @(posedge link_clk)
  begin
    if (!link_rst_n)
    begin
      phase <= PH_IDLE;
      hs_active <= 1'b0;
    end
    else if (start_ev)
      phase <= PH_FIRST;
    else if (stop_ev)
    begin
      phase <= PH_IDLE;
      hs_active <= 1'b0;
    end
    else if (byte_done)
    begin
      phase <= next_phase;
      if (first_mc)
        hs_active <= 1'b1;
    end
  end

  // bit slot counter and shift register
  always_ff @(posedge link_clk)
  begin
    if (!link_rst_n)
    begin
      bitcnt <= 4'h0;
      shreg <= 8'h00;
    end
    else if (start_ev)
      bitcnt <= 4'h0;
    else if (in_frame && scl_rise && bitcnt != SLOT_DONE)
    begin
      bitcnt <= bitcnt + 4'h1;
      if (bitcnt < ACK_SLOT)
        shreg <= full;
    end
    else if (in_frame && scl_fall && bitcnt == SLOT_DONE)
      bitcnt <= 4'h0;
  end

  // acknowledge driver: pull low from the fall before the ack clock
  // until the fall after it, so the line never moves with scl high
  always_ff @(posedge link_clk)
  begin
    if (!link_rst_n)
    begin
      ack_pend <= 1'b0;
      sda_drive <= 1'b0;
    end
    else if (start_ev || stop_ev)
      sda_drive <= 1'b0;
    else
    begin
      if (byte_done)
        ack_pend <= want_ack;
      if (in_frame && scl_fall && bitcnt == ACK_SLOT)
        sda_drive <= ack_pend;
      else if (scl_fall && bitcnt == SLOT_DONE)
        sda_drive <= 1'b0;
    end
  end

  // control byte and word pairing; the hand-off toggles once per word
  always_ff @(posedge link_clk)
  begin
    if (!link_rst_n)
    begin
      ctrl <= 8'h00;
      hi_byte <= 8'h00;
      second <= 1'b0;
      out_data <= 10'h000;
      out_chan <= 2'h0;
      out_load <= 2'h0;
      out_ext <= 2'h0;
      out_is_pd <= 1'b0;
      xfer_tgl <= 1'b0;
    end
    else if (start_ev || stop_ev)
      second <= 1'b0;
    else if (byte_done)
    begin
      if (phase == PH_CTRL)
      begin
        ctrl <= full;
        second <= 1'b0;
      end
      else if (phase == PH_DATA && !second)
      begin
        hi_byte <= full;
        second <= 1'b1;
      end
      else if (pair_end)
      begin
        second <= 1'b0;
        // low six bits of the second byte are dropped here
        out_data <= {hi_byte, full[7:LO_MSB_FIELD]};
        out_chan <= ctrl[CTRL_SEL+:2];
        out_load <= ctrl[CTRL_LOAD+:2];
        out_ext <= ctrl[CTRL_EXT+:2];
        out_is_pd <= ctrl_pd;
        xfer_tgl <= ~xfer_tgl;
      end
    end
  end

  // word hand-off into the core domain
  sample_sync #(.WIDTH(1)) u_xfer_sync
  (
    .clk(core_clk),
    .d(xfer_tgl),
    .q(xfer_s)
  );

  // fields are stable for many bus bits after each toggle
  wire xfer_new = xfer_s[0] ^ xfer_p;

  // core-side outputs, captured on each toggle edge
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      xfer_p <= 1'b0;
      word_valid <= 1'b0;
      powerdown_valid <= 1'b0;
      word_channel <= 2'h0;
      word_load_mode <= 2'h0;
      word_ext_addr <= 2'h0;
      word_data <= 10'h000;
      powerdown_mode_hi <= 1'b0;
      powerdown_mode_lo <= 1'b0;
    end
    else
    begin
      xfer_p <= xfer_s[0];
      word_valid <= xfer_new & ~out_is_pd;
      powerdown_valid <= xfer_new & out_is_pd;
      if (xfer_new)
      begin
        word_channel <= out_chan;
        word_load_mode <= out_load;
        word_ext_addr <= out_ext;
        word_data <= out_data;
        powerdown_mode_hi <= out_data[9];
        powerdown_mode_lo <= out_data[8];
      end
    end
  end
endmodule
`default_nettype wire

// ---- hw/hs_i2c_write_master.sv ----
// bus master end: sends one high-speed write per accepted command
// assumes the slave never stretches the clock; scl is divided locally
`timescale 1ns/10ps
`default_nettype none
module hs_i2c_write_master
(
  i2c_link_if.master link,
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_addr_pins,
  input wire logic [7:0] cmd_ctrl,
  input wire logic [9:0] cmd_data,
  input wire logic [1:0] cmd_pd_mode,
  output logic done,
  output logic nack_error
);
  import hs_i2c_pkg::*;

  tx_state_t state;
  tx_state_t next_state;
  logic [4:0] div;
  logic [1:0] qcnt;
  logic [3:0] bitn;
  logic scl_q;
  logic sda_q;
  logic [1:0] pins;
  logic [7:0] ctrl;
  logic [9:0] data;
  logic [1:0] pd_mode;
  logic [0:0] sda_s;

  // acknowledge sampling sees the wire through a synchroniser
  sample_sync #(.WIDTH(1)) u_sda_sync
  (
    .clk(core_clk),
    .d(link.sda),
    .q(sda_s)
  );

  // quarter-bit timing and byte selection
  wire tick = div == QUARTER_LAST;
  wire sym_end = tick & (qcnt == 2'h3);
  wire in_byte = (state == M_MCODE) | (state == M_ADDR) |
    (state == M_CTRL) | (state == M_HI) | (state == M_LO);
  wire slot_end = sym_end & in_byte & (bitn == ACK_SLOT);
  wire acked = ~sda_s[0];
  wire pd = ctrl[CTRL_PD];
  wire [7:0] hi_b = pd ? {pd_mode, 6'h00} : data[9:HI_LSB];
  wire [7:0] lo_b = pd ? 8'h00 : {data[1:0], 6'h00};
  wire [7:0] cur_byte =
    (state == M_MCODE) ? {MCODE_PREFIX, MCODE_ID} :
    (state == M_ADDR) ? addr_byte(pins) :
    (state == M_CTRL) ? ctrl :
    (state == M_HI) ? hi_b : lo_b;
  wire [2:0] bit_sel = 3'(4'h7 - bitn);
  wire chain = (state == M_LO) & slot_end & acked;
  // ack slot releases the line, which also leaves the code unacked
  wire byte_level = (bitn == ACK_SLOT) | cur_byte[bit_sel];
  wire want_sda =
    (state == M_START) ? (qcnt < 2'h2) :
    (state == M_RSTART) ? (qcnt != 2'h3) :
    (state == M_STOP) ? (qcnt == 2'h3) :
    in_byte ? byte_level : 1'b1;
  // sda only moves in quarters with scl low, except start and stop
  wire hold_sda = (qcnt == 2'h0) & (state != M_START) & (state != M_IDLE);
  wire next_sda = hold_sda ? sda_q : want_sda;
  // scl high only in quarters 2 and 3 outside idle and start: a slave ack released late in
  // quarter 1 must not look like a stop ahead of a repeated start
  wire next_scl = (state == M_IDLE) | (state == M_START) | qcnt[1];

  assign cmd_ready = (state == M_IDLE) | chain;
  assign link.scl = scl_q;
  assign link.sda_m_out = 1'b0;
  assign link.sda_m_oe = ~sda_q;

  // sequence of symbols within one transaction
  always_comb
  begin
    next_state = state;
    unique case (state)
      M_IDLE: next_state = cmd_valid ? M_START : M_IDLE;
      M_START: next_state = M_MCODE;
      M_MCODE: next_state = M_RSTART;
      M_RSTART: next_state = M_ADDR;
      M_ADDR: next_state = acked ? M_CTRL : M_STOP;
      M_CTRL: next_state = acked ? M_HI : M_STOP;
      M_HI: next_state = acked ? M_LO : M_STOP;
      M_LO: next_state = (acked && cmd_valid) ? M_RSTART : M_STOP;
      M_STOP: next_state = M_IDLE;
      default: next_state = M_IDLE;
    endcase
  end

  // state, bit and quarter counters
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state <= M_IDLE;
      div <= 5'h00;
      qcnt <= 2'h0;
      bitn <= 4'h0;
    end
    else if (state == M_IDLE)
    begin
      state <= next_state;
      div <= 5'h00;
      qcnt <= 2'h0;
      bitn <= 4'h0;
    end
    else
    begin
      div <= tick ? 5'h00 : div + 5'h01;
      if (tick)
        qcnt <= qcnt + 2'h1;
      if (sym_end && in_byte && bitn != ACK_SLOT)
        bitn <= bitn + 4'h1;
      else if (sym_end)
      begin
        bitn <= 4'h0;
        state <= next_state;
      end
    end
  end

  // command capture, line registers and result pulses
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      pins <= 2'h0;
      ctrl <= 8'h00;
      data <= 10'h000;
      pd_mode <= 2'h0;
      done <= 1'b0;
      nack_error <= 1'b0;
    end
    else
    begin
      scl_q <= next_scl;
      sda_q <= next_sda;
      if (cmd_valid && cmd_ready)
      begin
        pins <= cmd_addr_pins;
        ctrl <= cmd_ctrl;
        data <= cmd_data;
        pd_mode <= cmd_pd_mode;
      end
      done <= (state == M_LO) & slot_end & acked;
      nack_error <= slot_end & (state != M_MCODE) & ~acked;
    end
  end
endmodule
`default_nettype wire

// ---- bench/hs_i2c_link_checker.sv ----
// wire checks on the link between the master end and the slave end
// assumes core_clk far oversamples scl and sda
`timescale 1ns/10ps
`default_nettype none
module hs_i2c_link_checker
#(
  parameter logic [1:0] PINS = 2'h0
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_s_oe
);
  import hs_i2c_pkg::*;
  logic scl_q, sda_q, idle, fresh, hit, pd;
  logic [7:0] sh;
  logic [3:0] slot;
  logic [2:0] nbyte;
  // edge and condition decode
  wire logic [7:0] addr = {DEV_ADDR_PREFIX, PINS, WRITE_BIT};
  wire logic rise = scl & ~scl_q;
  wire logic ack = rise & (slot == ACK_SLOT);
  wire logic start = scl & scl_q & sda_q & ~sda;
  wire logic stop = scl & scl_q & ~sda_q & sda;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // bits shift in on each data clock rise
  always_ff @(posedge core_clk)
  begin
    scl_q <= rst_n ? scl : 1'b1;
    sda_q <= rst_n ? sda : 1'b1;
    if (rise && slot <= LAST_DATA_SLOT)
      sh <= {sh[6:0], sda};
  end

  // frame position; a start after a stop is fresh, a restart is not
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      slot <= 4'h0;
      nbyte <= 3'h0;
      idle <= 1'b1;
      fresh <= 1'b0;
    end
    else if (start)
    begin
      slot <= 4'h0;
      nbyte <= 3'h0;
      idle <= 1'b0;
      fresh <= idle;
    end
    else if (stop)
      idle <= 1'b1;
    else if (rise)
    begin
      slot <= ack ? 4'h0 : slot + 4'h1;
      nbyte <= ack ? nbyte + 3'h1 : nbyte;
    end
  end

  // address match and flag, latched at their ack clocks
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || start)
    begin
      hit <= 1'b0;
      pd <= 1'b0;
    end
    else if (ack && nbyte == 3'h0)
      hit <= !fresh && sh == addr;
    else if (ack && nbyte == 3'h1)
      pd <= sh[CTRL_PD];
  end

  mcode_fixed_a: assert property (
    ack && nbyte == 3'h0 && fresh |-> sh[7:3] == MCODE_PREFIX)
    else $error("bad master code");
  mcode_nack_a: assert property (
    ack && nbyte == 3'h0 && fresh |-> sda && !sda_s_oe)
    else $error("master code acked");
  addr_write_a: assert property (
    ack && nbyte == 3'h0 && !fresh |-> sh[0] == WRITE_BIT)
    else $error("address not a write");
  addr_ack_a: assert property (
    ack && nbyte == 3'h0 && !fresh && sh == addr |-> !sda)
    else $error("address not acked");
  addr_nack_a: assert property (
    ack && nbyte == 3'h0 && sh != addr |-> sda)
    else $error("foreign address acked");
  ctrl_ack_a: assert property (
    ack && nbyte == 3'h1 && hit |-> !sda)
    else $error("control not acked");
  word_ack_a: assert property (
    ack && nbyte >= 3'h2 && hit && !pd |-> !sda)
    else $error("data not acked");
  pd_ack_a: assert property (
    ack && nbyte inside {3'h2, 3'h3} && hit && pd |-> !sda)
    else $error("powerdown not acked");
  ack_hold_a: assert property (
    ack && !sda |-> sda_s_oe [*8])
    else $error("ack dropped early");
endmodule
`default_nettype wire

// ---- bench/hs_mode_i2c_write_slave_tb.sv ----
// bench: master end writes to the slave end across one link
// assumes both ends share rst_n; link_clk runs free
`timescale 1ns/10ps
`default_nettype none
module hs_mode_i2c_write_slave_tb;
  import hs_i2c_pkg::*;
  localparam logic [1:0] PINS = 2'h2;
  localparam logic [9:0] DV [4] = '{10'h3ff, 10'h000, 10'h2aa, 10'h155};
  logic core_clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0;
  logic [1:0] cmd_addr_pins = 2'h0, cmd_pd_mode = 2'h0;
  logic [7:0] cmd_ctrl = 8'h00;
  logic [9:0] cmd_data = 10'h000;
  logic cmd_ready, done, nack_error, word_valid, powerdown_valid;
  logic powerdown_mode_hi, powerdown_mode_lo;
  logic [1:0] word_channel, word_load_mode, word_ext_addr;
  logic [9:0] word_data;
  int n_fail = 0, num_checks = 0, n_done = 0, n_nack = 0;
  logic [15:0] words [$];
  logic [1:0] pds [$];

  i2c_link_if u_i2c_link_if ();
  hs_i2c_write_master u_hs_i2c_write_master (
    .link(u_i2c_link_if.master), .core_clk(core_clk), .rst_n(rst_n),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_addr_pins(cmd_addr_pins), .cmd_ctrl(cmd_ctrl),
    .cmd_data(cmd_data), .cmd_pd_mode(cmd_pd_mode), .done(done),
    .nack_error(nack_error));
  hs_mode_i2c_write_slave u_hs_mode_i2c_write_slave (
    .link(u_i2c_link_if.slave), .link_clk(link_clk),
    .core_clk(core_clk), .rst_n(rst_n), .addr_pin_hi(PINS[1]),
    .addr_pin_lo(PINS[0]), .word_valid(word_valid),
    .word_channel(word_channel), .word_load_mode(word_load_mode),
    .word_ext_addr(word_ext_addr), .word_data(word_data),
    .powerdown_valid(powerdown_valid),
    .powerdown_mode_hi(powerdown_mode_hi),
    .powerdown_mode_lo(powerdown_mode_lo));
  hs_i2c_link_checker #(.PINS(PINS)) u_hs_i2c_link_checker (
    .core_clk(core_clk), .rst_n(rst_n), .scl(u_i2c_link_if.scl),
    .sda(u_i2c_link_if.sda), .sda_s_oe(u_i2c_link_if.sda_s_oe));

  // odd link phase so the two clocks never line up
  always #2 core_clk = ~core_clk;
  initial
  begin
    #7.3;
    forever #16 link_clk = ~link_clk;
  end

  // record what both user sides report
  always @(posedge core_clk)
  begin
    if (word_valid === 1'b1)
      words.push_back({word_ext_addr, word_load_mode, word_channel,
                       word_data});
    if (powerdown_valid === 1'b1)
      pds.push_back({powerdown_mode_hi, powerdown_mode_lo});
    n_done += int'(done === 1'b1);
    n_nack += int'(nack_error === 1'b1);
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // hold a command until taken; a held request chains into the next
  task automatic send(input logic [1:0] p, input logic [7:0] c,
                      input logic [9:0] d, input logic [1:0] m);
    cmd_addr_pins <= p;
    cmd_ctrl <= c;
    cmd_data <= d;
    cmd_pd_mode <= m;
    cmd_valid <= 1'b1;
    do
      @(posedge core_clk);
    while (cmd_ready !== 1'b1);
  endtask

  // release the request, wait for n outcomes plus output latency
  task automatic wait_done(input int n);
    int k;
    k = 0;
    cmd_valid <= 1'b0;
    while (n_done + n_nack < n && k < 20000)
    begin
      @(posedge core_clk);
      k++;
    end
    // a transfer that never ends is a failure in its own right
    if (n_done + n_nack < n)
    begin
      n_fail++;
      $display("Error at %0t: no outcome within limit", $time);
    end
    repeat (40) @(posedge core_clk);
  endtask

  task automatic clear();
    words.delete();
    pds.delete();
    n_done = 0;
    n_nack = 0;
  endtask

  // four chained words, one per channel, edge data values
  task automatic t_words();
    clear();
    for (int i = 0; i < 4; i++)
      send(PINS, {2'(i), 2'(3 - i), 1'b0, 2'(i), 1'b0}, DV[i], 2'h0);
    wait_done(4);
    check(16'(words.size()), 16'h4);
    check(16'(n_done), 16'h4);
    for (int i = 0; i < 4; i++)
      check(words[i], {2'(i), 2'(3 - i), 2'(i), DV[i]});
    $display("test words finished");
  endtask

  // every powerdown mode, chained; no word may show
  task automatic t_powerdown();
    clear();
    for (int i = 0; i < 4; i++)
      send(PINS, {5'h00, 2'(i), 1'b1}, DV[i], 2'(i));
    wait_done(4);
    check(16'(pds.size()), 16'h4);
    check(16'(words.size()), 16'h0);
    for (int i = 0; i < 4; i++)
      check(16'(pds[i]), 16'(i));
    $display("test powerdown finished");
  endtask

  // foreign pins refused, then a fresh write from idle is taken
  task automatic t_bad_addr();
    clear();
    send(~PINS, 8'h30, 10'h201, 2'h0);
    wait_done(1);
    check(16'(n_nack), 16'h1);
    check(16'(words.size()), 16'h0);
    send(PINS, 8'h30, 10'h201, 2'h0);
    wait_done(2);
    check(16'(n_done), 16'h1);
    check(words[0], {6'h0c, 10'h201});
    $display("test bad address finished");
  endtask

  initial
  begin
    repeat (50) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (40) @(posedge core_clk);
    t_words();
    t_powerdown();
    t_bad_addr();
    close_out();
  end

  // cut a hang well past the expected run length
  initial
  begin
    repeat (60000) @(posedge core_clk);
    n_fail++;
    $display("Error at %0t: run timed out", $time);
    close_out();
  end
endmodule
`default_nettype wire
